//--- snvm_pkg.sv
// Shared constants of the serial nonvolatile byte memory slave.
// Assumes one system clock that samples every link pin.
package snvm_pkg;

    // ==========================================================
    // Command op-codes
    // ==========================================================
    localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
    localparam logic [7:0] MEM_READ_CMD          = 8'h03;
    localparam logic [7:0] MEM_WRITE_CMD         = 8'h02;

    // ==========================================================
    // Field positions and sizes
    // ==========================================================
    localparam int ARRAY_ADDR_W  = 13;
    localparam int BYTE_W        = 8;
    localparam int ADDR_BITS     = 16;
    localparam int STAT_PROT_BIT = 7;
    localparam int STAT_SPARE_HI = 6;
    localparam int STAT_SPARE_LO = 4;
    localparam int STAT_BP_HI    = 3;
    localparam int STAT_BP_LO    = 2;

    // ==========================================================
    // Counts and reset values
    // ==========================================================
    localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
    localparam logic [4:0] LAST_ADDR_BIT = 5'h0f;
    localparam logic [1:0] BUF_DEPTH     = 2'h2;
    localparam logic [2:0] SPARE_RESET   = 3'h0;
    localparam logic [1:0] BP_RESET      = 2'h0;

    // ==========================================================
    // Command sequencer states
    // ==========================================================
    typedef enum logic [2:0] {
        S_OP,
        S_ADDR,
        S_RSTAT,
        S_WSTAT,
        S_RDATA,
        S_WDATA,
        S_DONE
    } snvm_state_t;

endpackage : snvm_pkg

//--- snvm_mem.sv
// Byte array of the memory, one port, registered read data.
// Assumes one request per cycle; a read leaves its data until the next read.
module snvm_mem
    import snvm_pkg::*;
#(
    parameter int DATA_W = BYTE_W,
    parameter int ADDR_W = ARRAY_ADDR_W
)
(
    input  wire logic              clock,
    input  wire logic              en,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    // ==========================================================
    // Array port
    // ==========================================================
    always_ff @(posedge clock)
    begin
        if (en && we)
        begin
            cells[addr] <= wdata;
        end
        else if (en)
        begin
            rdata <= cells[addr];
        end
    end

endmodule : snvm_mem

//--- snvm_slave.sv
// Command logic of a serial nonvolatile byte memory on a four-wire link.
// Assumes all link pins are asynchronous to clock and far slower than it.
module snvm_slave
    import snvm_pkg::*;
#(
    parameter int ADDR_W = ARRAY_ADDR_W
)
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       hold_n,
    input  wire logic       wp_n,
    output logic            so,
    output logic            so_oe,
    output logic [7:0]      status_byte
);

    if (ADDR_W < 2 || ADDR_W > ADDR_BITS - 1)
    begin : g_bad_addr_w
        $error("snvm_slave: ADDR_W out of range");
    end

    typedef struct packed {
        logic                     cs_m, cs_s, sck_m, sck_s, sck_d;
        logic                     si_m, si_s, hold_m, hold_s, wp_m, wp_s;
        logic                     held;
        snvm_state_t              st;
        logic [4:0]               cnt;
        logic [ADDR_BITS-1:0]     sh_in;
        logic                     is_wr;
        logic                     clr_wel;
        logic [ADDR_W-1:0]        addr;
        logic [BYTE_W-1:0]        sh_out;
        logic                     so;
        logic                     so_oe;
        logic                     write_latch;
        logic                     status_protect_enable;
        logic [2:0]               spare;
        logic [1:0]               bp;
        logic                     rd_req;
        logic                     pend;
        logic [ADDR_W+BYTE_W-1:0] pend_w;
        logic [1:0]               bcnt;
        logic [ADDR_W+BYTE_W-1:0] b0;
        logic [ADDR_W+BYTE_W-1:0] b1;
    } snvm_regs_t;

    snvm_regs_t          r;
    snvm_regs_t          n;
    logic                rise;
    logic                fall;
    logic                op_done;
    logic [7:0]          op_val;
    logic                push;
    logic                pop;
    logic                mem_en;
    logic [ADDR_W-1:0]   mem_addr;
    logic [BYTE_W-1:0]   mem_rdata;
    logic [7:0]          stat_v;

    // Protected range: 01 top quarter, 10 top half, 11 all.
    function automatic logic is_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
        unique case (bp)
            2'h0: is_protected = 1'b0;
            2'h1: is_protected = &a[ADDR_W-1 -: 2];
            2'h2: is_protected = a[ADDR_W-1];
            2'h3: is_protected = 1'b1;
        endcase
    endfunction : is_protected

    function automatic logic [7:0] stat_of(input snvm_regs_t s);
        stat_of = {s.status_protect_enable, s.spare, s.bp, s.write_latch, 1'b0};
    endfunction : stat_of

    // ==========================================================
    // Array and its write buffer
    // ==========================================================
    // Reads win the port; the buffer absorbs writes meanwhile, so none is lost.
    assign pop      = (r.bcnt != 2'h0) && !r.rd_req;
    assign push     = r.pend && (r.bcnt != BUF_DEPTH || pop);
    assign mem_en   = r.rd_req || pop;
    assign mem_addr = r.rd_req ? r.addr : r.b0[ADDR_W+BYTE_W-1:BYTE_W];

    snvm_mem #(
        .DATA_W (BYTE_W),
        .ADDR_W (ADDR_W)
    ) u_mem (
        .clock  (clock),
        .en     (mem_en),
        .we     (!r.rd_req),
        .addr   (mem_addr),
        .wdata  (r.b0[BYTE_W-1:0]),
        .rdata  (mem_rdata)
    );

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb
    begin
        n       = r;
        stat_v  = stat_of(r);
        n.cs_m  = cs_n;
        n.cs_s  = r.cs_m;
        n.sck_m = sck;
        n.sck_s = r.sck_m;
        n.sck_d = r.sck_s;
        n.si_m  = si;
        n.si_s  = r.si_m;
        n.hold_m = hold_n;
        n.hold_s = r.hold_m;
        n.wp_m  = wp_n;
        n.wp_s  = r.wp_m;
        n.rd_req = 1'b0;
        n.pend  = r.pend && !push;
        op_val  = {r.sh_in[6:0], r.si_s};
        // While the clock is high the hold level is not taken over.
        n.held  = r.cs_s ? 1'b0 : (r.sck_s ? r.held : !r.hold_s);
        rise    = !r.held && !r.cs_s && r.sck_s && !r.sck_d;
        fall    = !r.held && !r.cs_s && !r.sck_s && r.sck_d;
        op_done = rise && (r.st == S_OP) && (r.cnt == LAST_BYTE_BIT);

        unique case ({push, pop})
            2'b10:
            begin
                if (r.bcnt == 2'h0) n.b0 = r.pend_w;
                else n.b1 = r.pend_w;
                n.bcnt = r.bcnt + 2'h1;
            end
            2'b01:
            begin
                n.b0   = r.b1;
                n.bcnt = r.bcnt - 2'h1;
            end
            2'b11:
            begin
                n.b0 = (r.bcnt == 2'h1) ? r.pend_w : r.b1;
                if (r.bcnt != 2'h1) n.b1 = r.pend_w;
            end
            default: ;
        endcase

        if (r.cs_s)
        begin
            n.st    = S_OP;
            n.cnt   = 5'h00;
            n.so_oe = 1'b0;
            if (r.clr_wel)
            begin
                n.write_latch     = 1'b0;
                n.clr_wel = 1'b0;
            end
        end
        else if (rise)
        begin
            n.sh_in = {r.sh_in[ADDR_BITS-2:0], r.si_s};
            n.cnt   = r.cnt + 5'h01;
            unique case (r.st)
                S_OP:
                begin
                    if (r.cnt == LAST_BYTE_BIT)
                    begin
                        n.cnt = 5'h00;
                        n.st  = S_DONE;
                        unique case (op_val)
                            SET_WRITE_LATCH_CMD:   n.write_latch = 1'b1;
                            CLEAR_WRITE_LATCH_CMD: n.write_latch = 1'b0;
                            STATUS_READ_CMD:       n.st = S_RSTAT;
                            STATUS_WRITE_CMD:
                            begin
                                n.st      = S_WSTAT;
                                n.clr_wel = 1'b1;
                            end
                            MEM_READ_CMD, MEM_WRITE_CMD:
                            begin
                                n.st      = S_ADDR;
                                n.is_wr   = (op_val == MEM_WRITE_CMD);
                                n.clr_wel = (op_val == MEM_WRITE_CMD);
                            end
                            default: ;
                        endcase
                    end
                end
                S_ADDR:
                begin
                    if (r.cnt == LAST_ADDR_BIT)
                    begin
                        n.cnt  = 5'h00;
                        n.addr = {r.sh_in[ADDR_W-2:0], r.si_s};
                        n.st   = r.is_wr ? S_WDATA : S_RDATA;
                        n.rd_req = !r.is_wr;
                    end
                end
                S_WSTAT:
                begin
                    if (r.cnt == LAST_BYTE_BIT)
                    begin
                        n.st = S_DONE;
                        if (r.write_latch && !(r.status_protect_enable && !r.wp_s))
                        begin
                            n.status_protect_enable  = op_val[STAT_PROT_BIT];
                            n.spare = op_val[STAT_SPARE_HI:STAT_SPARE_LO];
                            n.bp    = op_val[STAT_BP_HI:STAT_BP_LO];
                        end
                    end
                end
                S_WDATA:
                begin
                    if (r.cnt == LAST_BYTE_BIT)
                    begin
                        n.cnt  = 5'h00;
                        n.addr = r.addr + ADDR_W'(1);
                        if (r.write_latch && !is_protected(r.bp, r.addr))
                        begin
                            n.pend   = 1'b1;
                            n.pend_w = {r.addr, op_val};
                        end
                    end
                end
                S_RSTAT, S_RDATA:
                begin
                    // Input is ignored here; only the bit count matters.
                    if (r.cnt == LAST_BYTE_BIT) n.cnt = 5'h00;
                end
                default: n.cnt = r.cnt;
            endcase
        end
        else if (fall && (r.st == S_RSTAT || r.st == S_RDATA))
        begin
            if (r.cnt == 5'h00)
            begin
                n.so     = (r.st == S_RSTAT) ? stat_v[7] : mem_rdata[7];
                n.sh_out = (r.st == S_RSTAT) ? {stat_v[6:0], 1'b0} : {mem_rdata[6:0], 1'b0};
                if (r.st == S_RDATA)
                begin
                    // The next byte is fetched a whole byte time ahead.
                    n.addr   = r.addr + ADDR_W'(1);
                    n.rd_req = 1'b1;
                end
            end
            else
            begin
                n.so     = r.sh_out[7];
                n.sh_out = {r.sh_out[6:0], 1'b0};
            end
        end

        if (!r.cs_s) n.so_oe = !r.held && (r.st == S_RSTAT || r.st == S_RDATA);
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            r         <= '0;
            r.cs_m    <= 1'b1;
            r.cs_s    <= 1'b1;
            r.st      <= S_OP;
            r.spare   <= SPARE_RESET;
            r.bp      <= BP_RESET;
            r.write_latch     <= 1'b0;
        end
        else
        begin
            r <= n;
        end
    end

    assign so          = r.so;
    assign so_oe       = r.so_oe;
    assign status_byte = {r.status_protect_enable, r.spare, r.bp, r.write_latch, 1'b0};

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    desel_float_a: assert property (r.cs_s |=> !so_oe && r.st == S_OP)
        else $error("output driven or busy while deselected");
    held_float_a: assert property (r.held |=> !so_oe)
        else $error("output driven while held");
    held_freeze_a: assert property (r.held && !r.cs_s |=> $stable(r.cnt))
        else $error("bit count moved while held");
    latch_set_a: assert property (op_done && op_val == SET_WRITE_LATCH_CMD |=> r.write_latch)
        else $error("latch not set");
    latch_clr_a: assert property (op_done && op_val == CLEAR_WRITE_LATCH_CMD |=> !r.write_latch)
        else $error("latch not cleared");
    no_latch_write_a: assert property (!r.write_latch |=> $stable({r.status_protect_enable, r.spare, r.bp}) && !r.pend)
        else $error("write accepted without latch");
    prot_write_a: assert property (r.pend |-> !is_protected(r.bp, r.pend_w[ADDR_W+BYTE_W-1:BYTE_W]))
        else $error("protected address queued");
    stat_gate_a: assert property (rise && r.st == S_WSTAT && r.status_protect_enable && !r.wp_s |=> $stable(r.status_protect_enable))
        else $error("status written under pin protect");
    wel_done_a: assert property (r.cs_s && r.clr_wel |=> !r.write_latch)
        else $error("latch kept after write command");
    zero_bit_a: assert property (fall && r.st == S_RSTAT && r.cnt == LAST_BYTE_BIT |=> !so)
        else $error("status bit 0 not zero");

    rd_burst_c: cover property (r.st == S_RDATA && r.rd_req ##[1:300] r.st == S_RDATA && r.rd_req);
    wr_commit_c: cover property (push);
    hold_c: cover property (r.held && (r.st == S_RSTAT || r.st == S_RDATA));
    buf_full_c: cover property (r.bcnt == BUF_DEPTH);

endmodule : snvm_slave

//--- snvm_host_model.sv
// Host side of the four-wire link: an SPI master in mode 0.
// Assumes the bench calls one task at a time and supplies the system clock.
module snvm_host_model
(
    input  wire logic clock,
    input  wire logic so,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Line state
    // ==========================================================
    // An undriven output line shows the inverse of the last driven bit,
    // so a sample taken while it floats cannot match by luck.
    logic line;

    assign line = so_oe ? so : ~so;

    initial
    begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
    end

    // ==========================================================
    // Link tasks
    // ==========================================================
    // Every later step is a multiple of 5 ns, so no pin moves at a rising clock edge.
    task automatic sel();
        @(negedge clock);
        #2.5;
        cs_n = 1'b0;
        #50;
    endtask : sel

    task automatic desel();
        #50;
        cs_n = 1'b1;
        #200;
    endtask : desel

    // Shifts n bits of tx out, collecting the reply sampled before each rise.
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            si = tx[i];
            #60;
            rx = {rx[6:0], line};
            sck = 1'b1;
            #65;
            sck = 1'b0;
        end
        si = ~si;
    endtask : shift

    // With the clock low the pin acts at once, else at the next low phase.
    task automatic hold(input logic v);
        hold_n = v;
        #100;
    endtask : hold

    task automatic clock_level(input logic v);
        sck = v;
        #100;
    endtask : clock_level

    task automatic wiggle();
        repeat (3)
        begin
            si = ~si;
            #60;
            sck = 1'b1;
            #65;
            sck = 1'b0;
        end
    endtask : wiggle

endmodule : snvm_host_model

//--- snvm_slave_tb_top.sv
// Self-checking bench of the memory slave, driven through the host model.
// Assumes the slave's own assertions stand in its file.
module snvm_slave_tb_top
    import snvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals
    // ==========================================================
    logic        clock = 1'b0;
    logic        rst;
    logic        wp_n;
    logic        cs_n;
    logic        sck;
    logic        si;
    logic        hold_n;
    logic        so;
    logic        so_oe;
    logic [7:0]  status_byte;
    logic [7:0]  rx;
    logic [7:0]  hi;
    logic [7:0]  k;
    logic [7:0]  j;
    logic [7:0]  exp_mem [3];
    logic [15:0] addr_tbl [3] = '{16'h0000, 16'h1000, 16'h1800};
    int          miscompares = 0;
    int          tests_run = 0;

    always #5 clock = ~clock;

    snvm_slave #(.ADDR_W(ARRAY_ADDR_W)) dut
    (
        .clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .wp_n(wp_n), .so(so), .so_oe(so_oe), .status_byte(status_byte)
    );

    snvm_host_model host
    (
        .clock(clock), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n)
    );

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic test_done();
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic op(input logic [7:0] code);
        host.sel();
        host.shift(code, 8, rx);
        host.desel();
    endtask : op

    task automatic start(input logic [7:0] code, input logic [15:0] a);
        host.sel();
        host.shift(code, 8, rx);
        host.shift(a[15:8], 8, rx);
        host.shift(a[7:0], 8, rx);
    endtask : start

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic latch);
        if (latch)
            op(SET_WRITE_LATCH_CMD);
        start(MEM_WRITE_CMD, a);
        host.shift(d, 8, rx);
        host.desel();
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        start(MEM_READ_CMD, a);
        host.shift(8'hff, 8, rx);
        host.desel();
        check("read data", exp, rx);
        check("so_oe after deselect", 8'h00, {7'h00, so_oe});
    endtask : rd

    task automatic wsr(input logic [7:0] v);
        op(SET_WRITE_LATCH_CMD);
        host.sel();
        host.shift(STATUS_WRITE_CMD, 8, rx);
        host.shift(v, 8, rx);
        host.desel();
    endtask : wsr

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial
    begin
        rst = 1'b1;
        wp_n = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        check("status after reset", 8'h00, status_byte);
        check("so_oe after reset", 8'h00, {7'h00, so_oe});
        host.sel();
        host.shift(SET_WRITE_LATCH_CMD, 7, rx);
        host.desel();
        check("latch after cut op-code", 8'h00, status_byte);
        op(SET_WRITE_LATCH_CMD);
        check("latch set", 8'h02, status_byte);
        op(CLEAR_WRITE_LATCH_CMD);
        check("latch cleared", 8'h00, status_byte);
        wr(16'h0010, 8'h5a, 1'b1);
        check("latch after write", 8'h00, status_byte);
        wr(16'h0010, 8'ha5, 1'b0);
        rd(16'h0010, 8'h5a);
        // A burst across the top of the array with the high address bits set.
        op(SET_WRITE_LATCH_CMD);
        start(MEM_WRITE_CMD, 16'hfffe);
        for (k = 8'h00; k < 8'h03; k++)
            host.shift(8'hc1 + k, 8, rx);
        host.desel();
        start(MEM_READ_CMD, 16'h9ffe);
        for (k = 8'h00; k < 8'h03; k++)
        begin
            host.shift(8'ha5, 8, rx);
            check("burst read", 8'hc1 + k, rx);
        end
        host.desel();
        start(MEM_READ_CMD, 16'h1fff);
        host.shift(8'h00, 4, hi);
        host.hold(1'b0);
        check("so_oe while held", 8'h00, {7'h00, so_oe});
        host.wiggle();
        host.hold(1'b1);
        host.shift(8'h00, 4, rx);
        host.desel();
        check("read across hold", 8'hc2, {hi[3:0], rx[3:0]});
        op(SET_WRITE_LATCH_CMD);
        start(MEM_WRITE_CMD, 16'h0000);
        host.hold(1'b0);
        host.desel();
        host.hold(1'b1);
        rd(16'h0000, 8'hc3);
        wsr(8'hff);
        check("status after write", 8'hfc, status_byte);
        host.sel();
        host.shift(STATUS_READ_CMD, 8, rx);
        for (k = 8'h00; k < 8'h02; k++)
        begin
            host.shift(8'h5a, 8, rx);
            check("status read", 8'hfc, rx);
        end
        host.clock_level(1'b1);
        host.hold(1'b0);
        check("so_oe hold clock high", 8'h01, {7'h00, so_oe});
        host.clock_level(1'b0);
        check("so_oe hold clock low", 8'h00, {7'h00, so_oe});
        host.hold(1'b1);
        host.desel();
        @(negedge clock) wp_n = 1'b0;
        wsr(8'h00);
        check("status under pin protect", 8'hfc, status_byte);
        @(negedge clock) wp_n = 1'b1;
        wsr(8'h00);
        check("status with pin high", 8'h00, status_byte);
        // Every protect code against the base, the half and the top-quarter boundary addresses.
        for (k = 8'h00; k < 8'h04; k++)
        begin
            wsr({4'h0, k[1:0], 2'h0});
            for (j = 8'h00; j < 8'h03; j++)
            begin
                wr(addr_tbl[j], {k[3:0], j[3:0]}, 1'b1);
                if (!(k == 8'h03 || (k == 8'h02 && j > 8'h00) || (k == 8'h01 && j == 8'h02)))
                    exp_mem[j] = {k[3:0], j[3:0]};
            end
            for (j = 8'h00; j < 8'h03; j++)
                rd(addr_tbl[j], exp_mem[j]);
        end
        test_done();
    end

    initial
    begin
        #900000;
        miscompares++;
        test_done();
    end

endmodule : snvm_slave_tb_top
